// ### rtl/fcamc_cfg.v
// FIFO frame content and auxiliary master configuration registers
// Assumes a register port on the same clock; aux engine and FIFO outside
// Contract
// RQ1: FIFO content register resets 0x10; enables at bits 6..2, rest reserved.
// RQ2: Header enable stores a header per frame; off needs equal sensor rates.
// RQ3: Aux enable stores all three aux axes; off stores none.
// RQ4: Accel enable stores all three accel axes; off stores none.
// RQ5: Line-1 tag enable turns line-1 tagging on or off, reset off.
// RQ6: Line-2 tag enable turns line-2 tagging on or off, reset off.
// RQ7: Slave address in bits 7..1, bit 0 reserved, reset 0x20, used by master.
// RQ8: Burst codes 0..3 give 1, 2, 6, 8 bytes.
// RQ9: Manual bit set means setup mode, clear means data mode.
// RQ10: Aux settings reset 0x83, bits 6..2 reserved.
// RQ11: Read pointer register, 8 bits, reset 0x42.
// RQ12: Write pointer register, 8 bits, reset 0x4c.
// RQ13: Write data register, 8 bits, reset 0x02.
// RQ14: Rate field polls aux sensor, codes 1..11 valid, others reserved.
// RQ15: Reserved bits read zero and ignore writes.
// RQ16: In setup mode a data write starts one aux write; polling only in data mode.

// Macros are needed by the parameter default, so they come before the header
`include "fcamc_regs.vh"

module fcamc_cfg #(
	parameter POLL_BASE_CYC = `FCAMC_POLL_800_CYC
)
(
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Register port
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// FIFO frame controls
	output wire buffer_acc_store,
	output wire buffer_aux_store,
	output wire buffer_header_store,
	output wire buffer_line1_marker_on,
	output wire buffer_line2_marker_on,
	// Aux master controls
	output wire [6:0] aux_slave_addr,
	output reg [3:0] aux_burst_bytes,
	output wire aux_setup_mode,
	output wire [7:0] aux_read_reg,
	output wire [7:0] aux_write_reg,
	output wire [7:0] aux_write_byte,
	output reg aux_write_start,
	output reg aux_poll_start,
	input wire aux_busy
);

// ----------------------------------------
// Burst decode
// ----------------------------------------
localparam [1:0] run_one_byte = 2'h0;
localparam [1:0] run_two_bytes = 2'h1;
localparam [1:0] run_six_bytes = 2'h2;
localparam [1:0] run_eight_bytes = 2'h3;

function [3:0] burst_len;
	input [1:0] code;
	begin
		case (code)
			run_one_byte:
			begin
				burst_len = 4'h1;
			end
			run_two_bytes:
			begin
				burst_len = 4'h2;
			end
			run_six_bytes:
			begin
				burst_len = 4'h6;
			end
			run_eight_bytes:
			begin
				burst_len = 4'h8;
			end
			default:
			begin
				burst_len = 4'h8;
			end
		endcase
	end
endfunction

// Divider from 800 Hz: 2^(11-code) periods
function [11:0] rate_div;
	input [3:0] code;
	begin
		if (code >= `FCAMC_RATE_MIN && code <= `FCAMC_RATE_MAX)
			rate_div = 12'h001 << (`FCAMC_RATE_MAX - code);
		else
			rate_div = 12'h000;
	end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] fifo_frame_content_cfg;
reg [7:0] aux_slave_bus_address;
reg [7:0] aux_master_settings;
reg [7:0] aux_fetch_pointer;
reg [7:0] aux_store_pointer;
reg [7:0] aux_outgoing_byte;
reg [7:0] aux_poll_rate;

wire wr_out = reg_wr && reg_addr == `FCAMC_OFS_OUT_BYTE;

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		fifo_frame_content_cfg <= `FCAMC_RST_FIFO_CFG; // [RQ1] [RQ5] [RQ6]
		aux_slave_bus_address <= `FCAMC_RST_SLV_ADDR; // [RQ7]
		aux_master_settings <= `FCAMC_RST_AUX_SET; // [RQ10]
		aux_fetch_pointer <= `FCAMC_RST_FETCH_PTR; // [RQ11]
		aux_store_pointer <= `FCAMC_RST_STORE_PTR; // [RQ12]
		aux_outgoing_byte <= `FCAMC_RST_OUT_BYTE; // [RQ13]
		aux_poll_rate <= `FCAMC_RST_AUX_RATE;
	end
	else if (reg_wr)
	begin
		// Masks keep reserved bits at zero
		case (reg_addr)
			`FCAMC_OFS_FIFO_CFG:
			begin
				fifo_frame_content_cfg <= reg_wdata & `FCAMC_MSK_FIFO_CFG; // [RQ15]
			end
			`FCAMC_OFS_SLV_ADDR:
			begin
				aux_slave_bus_address <= reg_wdata & `FCAMC_MSK_SLV_ADDR; // [RQ15]
			end
			`FCAMC_OFS_AUX_SET:
			begin
				aux_master_settings <= reg_wdata & `FCAMC_MSK_AUX_SET; // [RQ15]
			end
			`FCAMC_OFS_FETCH_PTR:
			begin
				aux_fetch_pointer <= reg_wdata; // [RQ11]
			end
			`FCAMC_OFS_STORE_PTR:
			begin
				aux_store_pointer <= reg_wdata; // [RQ12]
			end
			`FCAMC_OFS_OUT_BYTE:
			begin
				aux_outgoing_byte <= reg_wdata; // [RQ13]
			end
			`FCAMC_OFS_AUX_RATE:
			begin
				aux_poll_rate <= reg_wdata; // [RQ14]
			end
			default:
			begin
				// Unmapped offsets are ignored
				aux_poll_rate <= aux_poll_rate;
			end
		endcase
	end
end

// ----------------------------------------
// Read back
// ----------------------------------------
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
		reg_rdata <= 8'h00;
	else if (reg_rd)
	begin
		case (reg_addr)
			`FCAMC_OFS_FIFO_CFG:
			begin
				reg_rdata <= fifo_frame_content_cfg; // [RQ15]
			end
			`FCAMC_OFS_SLV_ADDR:
			begin
				reg_rdata <= aux_slave_bus_address; // [RQ15]
			end
			`FCAMC_OFS_AUX_SET:
			begin
				reg_rdata <= aux_master_settings; // [RQ15]
			end
			`FCAMC_OFS_FETCH_PTR:
			begin
				reg_rdata <= aux_fetch_pointer;
			end
			`FCAMC_OFS_STORE_PTR:
			begin
				reg_rdata <= aux_store_pointer;
			end
			`FCAMC_OFS_OUT_BYTE:
			begin
				reg_rdata <= aux_outgoing_byte;
			end
			`FCAMC_OFS_AUX_RATE:
			begin
				reg_rdata <= aux_poll_rate;
			end
			default:
			begin
				reg_rdata <= 8'h00;
			end
		endcase
	end
end

// ----------------------------------------
// Field outputs
// ----------------------------------------
assign buffer_acc_store = fifo_frame_content_cfg[`FCAMC_BIT_ACC_EN]; // [RQ4]
assign buffer_aux_store = fifo_frame_content_cfg[`FCAMC_BIT_AUX_EN]; // [RQ3]
// Equal sensor rates without header are software's duty
assign buffer_header_store = fifo_frame_content_cfg[`FCAMC_BIT_HDR_EN]; // [RQ2]
assign buffer_line1_marker_on = fifo_frame_content_cfg[`FCAMC_BIT_TAG1_EN]; // [RQ5]
assign buffer_line2_marker_on = fifo_frame_content_cfg[`FCAMC_BIT_TAG2_EN]; // [RQ6]
assign aux_slave_addr = aux_slave_bus_address[7:1]; // [RQ7]
assign aux_setup_mode = aux_master_settings[`FCAMC_BIT_MANUAL]; // [RQ9]
assign aux_read_reg = aux_fetch_pointer;
assign aux_write_reg = aux_store_pointer;
assign aux_write_byte = aux_outgoing_byte;

// Registered decode costs one cycle of lag but keeps the output glitch free
always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		aux_burst_bytes <= 4'h8;
	end
	else
	begin
		aux_burst_bytes <= burst_len(aux_master_settings[1:0]); // [RQ8]
	end
end

// ----------------------------------------
// Manual write
// ----------------------------------------
reg write_pend;

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		write_pend <= 1'b0;
		aux_write_start <= 1'b0;
	end
	else
	begin
		aux_write_start <= 1'b0;
		// A write held while busy is issued later, not dropped
		if (wr_out && aux_setup_mode)
		begin
			write_pend <= 1'b1; // [RQ16]
		end
		else if (write_pend && !aux_busy)
		begin
			write_pend <= 1'b0;
			aux_write_start <= 1'b1; // [RQ16]
		end
	end
end

// ----------------------------------------
// Poll base counter
// ----------------------------------------
localparam [31:0] BASE_LAST = POLL_BASE_CYC - 1;
reg [31:0] base_cnt;
wire base_tick = base_cnt == BASE_LAST;

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		base_cnt <= 32'h0;
	end
	else if (base_tick)
	begin
		base_cnt <= 32'h0;
	end
	else
	begin
		base_cnt <= base_cnt + 32'h1;
	end
end

// ----------------------------------------
// Poll timer
// ----------------------------------------
reg [11:0] tick_cnt;
wire [11:0] div = rate_div(aux_poll_rate[3:0]);

always @(posedge clk or posedge sys_rst)
begin
	if (sys_rst)
	begin
		tick_cnt <= 12'h000;
		aux_poll_start <= 1'b0;
	end
	else
	begin
		aux_poll_start <= 1'b0;
		// Reserved rate codes stop polling rather than guess a rate
		if (aux_setup_mode || div == 12'h000)
		begin
			tick_cnt <= 12'h000; // [RQ14] [RQ16]
		end
		else if (base_tick)
		begin
			if (tick_cnt + 12'h001 >= div)
			begin
				tick_cnt <= 12'h000;
				// A busy engine skips this poll; the next one comes a period later
				aux_poll_start <= !aux_busy; // [RQ14]
			end
			else
			begin
				tick_cnt <= tick_cnt + 12'h001;
			end
		end
	end
end

endmodule

// ### rtl/fcamc_regs.vh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the FIFO content and aux master register slice
`ifndef FCAMC_REGS_VH
`define FCAMC_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define FCAMC_OFS_AUX_RATE 8'h44
`define FCAMC_OFS_FIFO_CFG 8'h49
`define FCAMC_OFS_SLV_ADDR 8'h4b
`define FCAMC_OFS_AUX_SET 8'h4c
`define FCAMC_OFS_FETCH_PTR 8'h4d
`define FCAMC_OFS_STORE_PTR 8'h4e
`define FCAMC_OFS_OUT_BYTE 8'h4f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCAMC_RST_AUX_RATE 8'h46
`define FCAMC_RST_FIFO_CFG 8'h10
`define FCAMC_RST_SLV_ADDR 8'h20
`define FCAMC_RST_AUX_SET 8'h83
`define FCAMC_RST_FETCH_PTR 8'h42
`define FCAMC_RST_STORE_PTR 8'h4c
`define FCAMC_RST_OUT_BYTE 8'h02

// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define FCAMC_MSK_FIFO_CFG 8'h7c
`define FCAMC_MSK_SLV_ADDR 8'hfe
`define FCAMC_MSK_AUX_SET 8'h83

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCAMC_BIT_ACC_EN 6
`define FCAMC_BIT_AUX_EN 5
`define FCAMC_BIT_HDR_EN 4
`define FCAMC_BIT_TAG1_EN 3
`define FCAMC_BIT_TAG2_EN 2
`define FCAMC_BIT_MANUAL 7

// ----------------------------------------
// Rate codes and timing
// ----------------------------------------
`define FCAMC_RATE_MIN 4'h1
`define FCAMC_RATE_MAX 4'hb
`define FCAMC_CLK_HZ 100000000
// Cycles of the fastest poll rate, 800 Hz
`define FCAMC_POLL_800_CYC (`FCAMC_CLK_HZ / 800)

`endif

// ### sim/fcamc_aux_peer.sv
// Aux engine model: busy for a while after each start pulse
// Assumes the slice clock and its active-high async reset
module fcamc_aux_peer (
	input wire clk,
	input wire sys_rst,
	input wire aux_write_start,
	input wire aux_poll_start,
	output logic aux_busy,
	output logic [7:0] wr_cnt,
	output logic [7:0] poll_cnt
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] left;
	// Slow answer, so a second write has to wait
	assign aux_busy = left != 3'h0;
	always @(posedge clk or posedge sys_rst)
		if (sys_rst)
			{left, wr_cnt, poll_cnt} <= 19'h00000;
		else
		begin
			wr_cnt <= wr_cnt + {7'h00, aux_write_start};
			poll_cnt <= poll_cnt + {7'h00, aux_poll_start};
			if (aux_write_start || aux_poll_start)
				left <= 3'h6;
			else if (aux_busy)
				left <= left - 3'h1;
		end
endmodule

// ### sim/fcamc_cfg_chk.sv
// Port assertions for the FIFO content and aux master register slice
// Assumes a bind onto fcamc_cfg; sees its ports only
module fcamc_cfg_chk (
	input wire clk,
	input wire sys_rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire buffer_header_store,
	input wire [6:0] aux_slave_addr,
	input wire [3:0] aux_burst_bytes,
	input wire aux_setup_mode,
	input wire [7:0] aux_read_reg,
	input wire aux_write_start,
	input wire aux_poll_start,
	input wire aux_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire w4c = reg_wr && reg_addr == 8'h4c;
	sequence s_setup_wr;
		reg_wr && reg_addr == 8'h4f && aux_setup_mode ##1 !aux_busy;
	endsequence
	property p_hdr; reg_wr && reg_addr == 8'h49 |=> buffer_header_store == $past(reg_wdata[4]); endproperty
	a_hdr: assert property (p_hdr) else $error("hdr");
	property p_slv; reg_wr && reg_addr == 8'h4b |=> aux_slave_addr == $past(reg_wdata[7:1]); endproperty
	a_slv: assert property (p_slv) else $error("slv");
	property p_bl; w4c && reg_wdata[1:0] == 2'h2 |=> ##1 aux_burst_bytes == 4'h6; endproperty
	a_bl: assert property (p_bl) else $error("bl");
	property p_mode; w4c |=> aux_setup_mode == $past(reg_wdata[7]); endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_ptr; reg_wr && reg_addr == 8'h4d |=> aux_read_reg == $past(reg_wdata); endproperty
	a_ptr: assert property (p_ptr) else $error("ptr");
	property p_rsv; reg_rd && reg_addr == 8'h49 |=> (reg_rdata & 8'h83) == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv");
	property p_wst; s_setup_wr |=> aux_write_start; endproperty
	a_wst: assert property (p_wst) else $error("wst");
	property p_poll; aux_poll_start |-> !$past(aux_setup_mode); endproperty
	a_poll: assert property (p_poll) else $error("poll");
endmodule
bind fcamc_cfg fcamc_cfg_chk u_chk (.*);

// ### sim/test_fcamc_cfg.sv
// Self-checking bench for the FIFO content and aux master slice
// Assumes the slice, the aux model and the checker compiled first
module test_fcamc_cfg;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
	wire [7:0] reg_rdata, aux_read_reg, aux_write_reg, aux_write_byte, wr_cnt, poll_cnt;
	wire buffer_acc_store, buffer_aux_store, buffer_header_store, aux_setup_mode, aux_busy;
	wire buffer_line1_marker_on, buffer_line2_marker_on, aux_write_start, aux_poll_start;
	wire [6:0] aux_slave_addr;
	wire [3:0] aux_burst_bytes;
	int num_errors = 0, checks_done = 0, n;
	logic [15:0] rr[7] = '{16'h4446, 16'h4910, 16'h4b20, 16'h4c83, 16'h4d42, 16'h4e4c, 16'h4f02};
	logic [3:0] bl[4] = '{4'h1, 4'h2, 4'h6, 4'h8};
	always #5 clk = ~clk;
	// Short poll base keeps the run brief
	fcamc_cfg #(.POLL_BASE_CYC(10)) u_fcamc_cfg (.*);
	fcamc_aux_peer u_fcamc_aux_peer (.*);
	task wr(input [7:0] a, v);
		@(posedge clk) #1;
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
		@(posedge clk) #1;
		reg_wr = 0;
	endtask
	task cmp(input [7:0] g, e);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask
	task rdc(input [7:0] a, e);
		@(posedge clk) #1;
		{reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk) #1;
		reg_rd = 0;
		cmp(reg_rdata, e);
	endtask
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		num_errors++;
		give_verdict;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 0;
		for (n = 0; n < 7; n++)
			rdc(rr[n][15:8], rr[n][7:0]);
		rdc(8'h50, 8'h00);
		$display("reset done");
		wr(8'h49, 8'hff);
		cmp({1'b0, buffer_acc_store, buffer_aux_store, buffer_header_store,
			buffer_line1_marker_on, buffer_line2_marker_on, 2'h0}, 8'h7c);
		rdc(8'h49, 8'h7c);
		wr(8'h4b, 8'hff);
		cmp({1'b0, aux_slave_addr}, 8'h7f);
		rdc(8'h4b, 8'hfe);
		for (n = 0; n < 4; n++)
		begin
			wr(8'h4c, 8'hfc | n[7:0]);
			@(posedge clk) #1;
			cmp({4'h0, aux_burst_bytes}, {4'h0, bl[n]});
			rdc(8'h4c, 8'h80 | n[7:0]);
		end
		$display("fields done");
		wr(8'h4d, 8'ha5);
		wr(8'h4e, 8'h5a);
		wr(8'h4f, 8'hc3);
		wr(8'h4f, 8'h3c);
		cmp(aux_read_reg, 8'ha5);
		cmp(aux_write_reg, 8'h5a);
		cmp(aux_write_byte, 8'h3c);
		#200 cmp(wr_cnt, 8'h02);
		wr(8'h44, 8'h0b);
		wr(8'h4c, 8'h03);
		cmp({7'h00, aux_setup_mode}, 8'h00);
		wr(8'h4f, 8'h11);
		#600 cmp(wr_cnt, 8'h02);
		cmp({7'h00, poll_cnt > 8'h03}, 8'h01);
		wr(8'h44, 8'h0c);
		#20 d = poll_cnt;
		#400 cmp(poll_cnt, d);
		$display("aux done");
		give_verdict;
	end
endmodule
